/* rtl/mcr_defines.svh */
// register offsets, field positions and reset values of the maintenance channel registers
//
// Contract
// - host reads and writes registers through control port
// - m4 transmit drives link, receive returns link
// - m5/m6 transmit drives link, receive returns link
// - one eoc register carries both eoc directions
// - error counters hold and count through sync loss
// - automatic mode: device trinal-checks and executes eoc
// - trinal check only act, dea, uoa; others dual
// - group select b0 maps init group registers
// - m4 trinal check register b0 enables trinal
// - mode register 1C selects auto eoc, dual check
// - interrupt enable A enables activation and m4
// - m4 interrupt when validated bits differ from receive
`ifndef MCR_DEFINES_SVH
`define MCR_DEFINES_SVH

// nibble register addresses
`define MCR_ADDR_RESET_CTRL 6'h00
`define MCR_ADDR_STATUS 6'h01
`define MCR_ADDR_ACT_CTRL 6'h02
`define MCR_ADDR_IRQ_STATUS 6'h03
`define MCR_ADDR_IRQ_ENABLE 6'h04
// eoc register, twelve bits over two addresses
`define MCR_ADDR_EOC_LO 6'h06
`define MCR_ADDR_EOC_HI 6'h07
// byte register addresses
`define MCR_ADDR_M4_TX 6'h10
`define MCR_ADDR_M4_RX 6'h11
`define MCR_ADDR_M56_TX 6'h12
`define MCR_ADDR_M56_RX 6'h13
`define MCR_ADDR_FEBE 6'h14
`define MCR_ADDR_NEBE 6'h15
`define MCR_ADDR_MODE 6'h19
`define MCR_ADDR_GROUP 6'h1A
// init group register, visible only while the group is selected
`define MCR_ADDR_TRINAL 6'h17

// field positions
`define MCR_SOFT_RESET_BIT 3
`define MCR_ACT_REQ_BIT 3
`define MCR_CUST_EN_BIT 0
`define MCR_IRQ_ACT_BIT 3
`define MCR_IRQ_M4_BIT 1
`define MCR_GROUP_INIT_BIT 0
`define MCR_TRINAL_EN_BIT 0
`define MCR_MODE_NONAUTO_BIT 7
`define MCR_MODE_M4CHK_MSB 5
`define MCR_MODE_M4CHK_LSB 4
`define MCR_MODE_M56_EVERY_BIT 3
`define MCR_MODE_FEBE_NEBE_BIT 2
`define MCR_M4_ACT_BIT 7
`define MCR_M4_DEA_BIT 6
`define MCR_M4_UOA_BIT 5
`define MCR_M56_FEBE_BIT 4

// m4 check mode field values
`define MCR_M4CHK_NONE 2'h0

// reset values
`define MCR_RST_BYTE_ONES 8'hFF
`define MCR_RST_BYTE_ZERO 8'h00
`define MCR_RST_NIBBLE 4'h0
`define MCR_RST_EOC 12'hFFF
`define MCR_COUNTER_MAX 8'hFF

// eoc message fields and codes
`define MCR_EOC_ADDR_NT 3'h1
`define MCR_EOC_ADDR_BCAST 3'h7
`define MCR_EOC_RETURN_NORMAL 8'hFF
`define MCR_EOC_LOOPBACK 8'h50
`define MCR_EOC_UNABLE 8'h00
`define MCR_EOC_MATCH_MAX 2'h2

`endif

/* rtl/mcr_eoc_auto.sv */
// trinal check of received eoc frames and automatic network-end response
`include "mcr_defines.svh"
module mcr_eoc_auto import mcr_pkg::*; (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic autoMode,
   input wire logic [11:0] rxEoc,
   input wire logic rxValid,
   output logic [11:0] validMsg,
   output logic validStrobe,
   output logic [11:0] autoTx,
   output logic loopbackActive
);
   logic [11:0] lastRx;      // last raw frame
   logic [1:0] matchCount;   // identical frames seen after the first
   logic [11:0] next_lastRx;
   logic [1:0] next_matchCount;
   logic [11:0] next_validMsg;
   logic next_validStrobe;
   logic [11:0] next_autoTx;
   logic next_loopbackActive;
   logic third;              // this frame is the third identical frame
   logic forUs;              // addressed to this end or broadcast

   // the third identical frame validates; longer runs do not re-trigger
   always_comb begin
      next_lastRx = lastRx;
      next_matchCount = matchCount;
      next_validMsg = validMsg;
      next_validStrobe = 1'b0;
      next_autoTx = autoTx;
      next_loopbackActive = loopbackActive;
      third = 1'b0;
      forUs = (rxEoc[11:9] == `MCR_EOC_ADDR_NT) || (rxEoc[11:9] == `MCR_EOC_ADDR_BCAST);
      if (clear) begin
         next_matchCount = 2'h0;
         next_loopbackActive = 1'b0;
         next_autoTx = `MCR_RST_EOC;
      end else if (rxValid) begin
         next_lastRx = rxEoc;
         if (rxEoc != lastRx) begin
            next_matchCount = 2'h0;
         end else if (matchCount != `MCR_EOC_MATCH_MAX) begin
            next_matchCount = matchCount + 2'h1;
            third = (matchCount == 2'h1);
         end
      end
      if (third) begin
         next_validMsg = rxEoc;
         next_validStrobe = 1'b1;
         // device decodes and acts with no host help
         if (autoMode && forUs) begin
            if (rxEoc[7:0] == `MCR_EOC_RETURN_NORMAL) begin
               next_loopbackActive = 1'b0;
               next_autoTx = rxEoc;
            end else if (rxEoc[7:0] == `MCR_EOC_LOOPBACK) begin
               next_loopbackActive = 1'b1;
               next_autoTx = rxEoc;
            end else begin
               // unknown command answered, never silently echoed
               next_autoTx = {rxEoc[11:8], `MCR_EOC_UNABLE};
            end
         end
      end
   end

   // checker state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lastRx <= `MCR_RST_EOC;
         matchCount <= 2'h0;
         validMsg <= `MCR_RST_EOC;
         validStrobe <= 1'b0;
         autoTx <= `MCR_RST_EOC;
         loopbackActive <= 1'b0;
      end else begin
         lastRx <= next_lastRx;
         matchCount <= next_matchCount;
         validMsg <= next_validMsg;
         validStrobe <= next_validStrobe;
         autoTx <= next_autoTx;
         loopbackActive <= next_loopbackActive;
      end
   end
endmodule // mcr_eoc_auto

/* rtl/mcr_m4_check.sv */
// consecutive-frame validation of received m4 bits
`include "mcr_defines.svh"
module mcr_m4_check import mcr_pkg::*; (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic [7:0] rxBits,
   input wire logic rxValid,
   input wire logic trinalEn,
   input wire logic [1:0] checkMode,
   output logic [7:0] validated,
   output logic updated
);
   logic [7:0] prev1;      // frame before this one
   logic [7:0] prev2;      // frame before that
   logic [7:0] accept;     // per bit, new value may be taken
   logic [7:0] next_prev1;
   logic [7:0] next_prev2;
   logic [7:0] next_validated;
   logic next_updated;

   // act, dea and uoa may need a third matching frame
   generate
      for (genvar i = 0; i < 8; i++) begin : gBit
         localparam bit IS_TRINAL = (i == `MCR_M4_ACT_BIT) || (i == `MCR_M4_DEA_BIT) ||
                                    (i == `MCR_M4_UOA_BIT);
         // mode none passes every frame straight through
         assign accept[i] = (checkMode == `MCR_M4CHK_NONE) ||
                            ((rxBits[i] == prev1[i]) &&
                             (!(IS_TRINAL && trinalEn) || (rxBits[i] == prev2[i])));
      end
   endgenerate

   // shift history and update the accepted bits
   always_comb begin
      next_prev1 = prev1;
      next_prev2 = prev2;
      next_validated = validated;
      next_updated = 1'b0;
      if (clear) begin
         next_prev1 = `MCR_RST_BYTE_ONES;
         next_prev2 = `MCR_RST_BYTE_ONES;
         next_validated = `MCR_RST_BYTE_ONES;
      end else if (rxValid) begin
         next_prev1 = rxBits;
         next_prev2 = prev1;
         next_validated = (rxBits & accept) | (validated & ~accept);
         next_updated = 1'b1;
      end
   end

   // history registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev1 <= `MCR_RST_BYTE_ONES;
         prev2 <= `MCR_RST_BYTE_ONES;
         validated <= `MCR_RST_BYTE_ONES;
         updated <= 1'b0;
      end else begin
         prev1 <= next_prev1;
         prev2 <= next_prev2;
         validated <= next_validated;
         updated <= next_updated;
      end
   end
endmodule // mcr_m4_check

/* rtl/mcr_pkg.sv */
// types shared by the maintenance channel register block
package mcr_pkg;

   // what the line side hands in, one frame field at a time
   typedef struct packed {
      logic [7:0] m4;        // raw received m4 bits
      logic m4Valid;         // one-cycle pulse per received frame
      logic [7:0] m5m6;      // raw received m5/m6 bits
      logic m5m6Valid;       // one-cycle pulse
      logic [11:0] eoc;      // raw received eoc frame
      logic eocValid;        // one-cycle pulse
      logic febeErr;         // far-end block error seen
      logic nebeErr;         // near-end crc error computed
   } mcr_link_rx_t;

   // what the block sends to the line side
   typedef struct packed {
      logic [7:0] m4;
      logic [7:0] m5m6;
      logic [11:0] eoc;
      logic febeBit;         // high means no error
   } mcr_link_tx_t;

   // control port access sequencer
   typedef enum logic [1:0] {
      PORT_IDLE,
      PORT_WRITE,
      PORT_READ
   } mcr_port_state_t;

endpackage

/* rtl/mcr_regs.sv */
// maintenance channel register bank behind the parallel control port
`include "mcr_defines.svh"
module mcr_regs import mcr_pkg::*; (
   input wire logic clock,
   input wire logic rst_n,
   // parallel control port pins, asynchronous to clock
   input wire logic pcpSelectN,
   input wire logic pcpWriteN,
   input wire logic pcpReadN,
   input wire logic [5:0] pcpAddr,
   input wire logic [7:0] pcpDataIn,
   output logic [7:0] pcpDataOut,
   output logic pcpDataOe,
   // line side
   input wire mcr_link_rx_t linkRx,
   output mcr_link_tx_t linkTx,
   input wire logic [3:0] statusIn,
   input wire logic activationEvent,
   output logic softReset,
   output logic activationRequest,
   output logic customerEnable,
   output logic loopbackActive,
   output logic m4ChannelInterrupt,
   output logic activationDchannelInterrupt
);
   // pin synchroniser, first stage read only by the second
   logic [16:0] syncA;
   logic [16:0] syncB;
   logic sSelN;
   logic sWriteN;
   logic sReadN;
   logic [5:0] sAddr;
   logic [7:0] sData;

   // registers
   logic [3:0] resetCtrl;       // reset_control_nibble
   logic [3:0] actCtrl;         // activation_control_nibble
   logic [3:0] irqEnable;       // interrupt_enable_nibble
   logic [7:0] m4Tx;            // m4_transmit
   logic [7:0] m4Rx;            // m4_receive
   logic [7:0] m56Tx;           // m5_m6_transmit
   logic [7:0] m56Rx;           // m5_m6_receive
   logic [7:0] febeCount;       // far_end_error_counter
   logic [7:0] nebeCount;       // near_end_error_counter
   logic [7:0] modeCfg;         // maintenance_mode_config
   logic [7:0] groupSel;        // register_group_select
   logic [7:0] trinalCfg;       // m4_trinal_check_config
   logic [11:0] eocTx;          // eoc written by the host
   logic [11:0] eocRx;          // last validated eoc
   logic irqM4Flag;             // sticky m4 change
   logic irqActFlag;            // sticky activation event
   logic [7:0] m56Prev;         // previous raw m5/m6 frame
   mcr_port_state_t portState;
   logic [7:0] rdData;

   logic [3:0] next_resetCtrl;
   logic [3:0] next_actCtrl;
   logic [3:0] next_irqEnable;
   logic [7:0] next_m4Tx;
   logic [7:0] next_m4Rx;
   logic [7:0] next_m56Tx;
   logic [7:0] next_m56Rx;
   logic [7:0] next_febeCount;
   logic [7:0] next_nebeCount;
   logic [7:0] next_modeCfg;
   logic [7:0] next_groupSel;
   logic [7:0] next_trinalCfg;
   logic [11:0] next_eocTx;
   logic [11:0] next_eocRx;
   logic next_irqM4Flag;
   logic next_irqActFlag;
   logic [7:0] next_m56Prev;
   mcr_port_state_t next_portState;
   logic [7:0] next_rdData;
   mcr_link_tx_t next_linkTx;

   // helpers
   logic wrStb;                 // one-cycle write commit
   logic rdStb;                 // one-cycle read capture
   logic initGroup;             // init group mapped in
   logic autoMode;
   logic [7:0] m4Valid;
   logic m4Updated;
   logic [11:0] eocValid;
   logic eocStrobe;
   logic [11:0] eocAutoTx;

   assign sSelN = syncB[16];
   assign sWriteN = syncB[15];
   assign sReadN = syncB[14];
   assign sAddr = syncB[13:8];
   assign sData = syncB[7:0];
   assign initGroup = groupSel[`MCR_GROUP_INIT_BIT];
   assign autoMode = !modeCfg[`MCR_MODE_NONAUTO_BIT];

   // counter step that saturates, shared by both error counters
   function automatic logic [7:0] countStep(input logic [7:0] base, input logic evt);
      countStep = (evt && base != `MCR_COUNTER_MAX) ? base + 8'h01 : base;
   endfunction

   // register read decode
   function automatic logic [7:0] readMux(input logic [5:0] a);
      readMux = `MCR_RST_BYTE_ZERO;
      if (a == `MCR_ADDR_RESET_CTRL) begin
         readMux = {4'h0, resetCtrl};
      end else if (a == `MCR_ADDR_STATUS) begin
         readMux = {4'h0, statusIn};
      end else if (a == `MCR_ADDR_ACT_CTRL) begin
         readMux = {4'h0, actCtrl};
      end else if (a == `MCR_ADDR_IRQ_STATUS) begin
         readMux = {4'h0, irqActFlag, 1'b0, irqM4Flag, 1'b0};
      end else if (a == `MCR_ADDR_IRQ_ENABLE) begin
         readMux = {4'h0, irqEnable};
      end else if (a == `MCR_ADDR_EOC_LO) begin
         readMux = eocRx[7:0];
      end else if (a == `MCR_ADDR_EOC_HI) begin
         readMux = {4'h0, eocRx[11:8]};
      end else if (a == `MCR_ADDR_GROUP) begin
         readMux = groupSel;
      end else if (initGroup) begin
         // byte space holds only the init group and group select while selected
         if (a == `MCR_ADDR_TRINAL) begin
            readMux = trinalCfg;
         end
      end else if (a == `MCR_ADDR_M4_TX) begin
         readMux = m4Tx;
      end else if (a == `MCR_ADDR_M4_RX) begin
         readMux = m4Rx;
      end else if (a == `MCR_ADDR_M56_TX) begin
         readMux = m56Tx;
      end else if (a == `MCR_ADDR_M56_RX) begin
         readMux = m56Rx;
      end else if (a == `MCR_ADDR_FEBE) begin
         readMux = febeCount;
      end else if (a == `MCR_ADDR_NEBE) begin
         readMux = nebeCount;
      end else if (a == `MCR_ADDR_MODE) begin
         readMux = modeCfg;
      end
   endfunction

   mcr_m4_check uM4Check (
      .clock(clock),
      .rst_n(rst_n),
      .clear(softReset),
      .rxBits(linkRx.m4),
      .rxValid(linkRx.m4Valid),
      .trinalEn(trinalCfg[`MCR_TRINAL_EN_BIT]),
      .checkMode(modeCfg[`MCR_MODE_M4CHK_MSB:`MCR_MODE_M4CHK_LSB]),
      .validated(m4Valid),
      .updated(m4Updated)
   );

   mcr_eoc_auto uEocAuto (
      .clock(clock),
      .rst_n(rst_n),
      .clear(softReset),
      .autoMode(autoMode),
      .rxEoc(linkRx.eoc),
      .rxValid(linkRx.eocValid),
      .validMsg(eocValid),
      .validStrobe(eocStrobe),
      .autoTx(eocAutoTx),
      .loopbackActive(loopbackActive)
   );

   // port sequencer: one access per strobe, held until the strobe lifts
   always_comb begin
      next_portState = portState;
      wrStb = 1'b0;
      rdStb = 1'b0;
      case (portState)
         PORT_IDLE: begin
            if (!sSelN && !sWriteN) begin
               wrStb = 1'b1;
               next_portState = PORT_WRITE;
            end else if (!sSelN && !sReadN) begin
               rdStb = 1'b1;
               next_portState = PORT_READ;
            end
         end
         PORT_WRITE: begin
            if (sSelN || sWriteN) begin
               next_portState = PORT_IDLE;
            end
         end
         default: begin
            if (sSelN || sReadN) begin
               next_portState = PORT_IDLE;
            end
         end
      endcase
   end

   // data bus driven only while a read strobe is held
   assign pcpDataOe = (portState == PORT_READ) && !sSelN && !sReadN;
   assign pcpDataOut = rdData;
   assign softReset = resetCtrl[`MCR_SOFT_RESET_BIT];
   assign activationRequest = actCtrl[`MCR_ACT_REQ_BIT];
   assign customerEnable = actCtrl[`MCR_CUST_EN_BIT];
   assign m4ChannelInterrupt = irqM4Flag && irqEnable[`MCR_IRQ_M4_BIT];
   assign activationDchannelInterrupt = irqActFlag && irqEnable[`MCR_IRQ_ACT_BIT];

   // register writes, link updates and sticky flags
   always_comb begin
      next_resetCtrl = resetCtrl;
      next_actCtrl = actCtrl;
      next_irqEnable = irqEnable;
      next_m4Tx = m4Tx;
      next_m4Rx = m4Rx;
      next_m56Tx = m56Tx;
      next_m56Rx = m56Rx;
      next_febeCount = febeCount;
      next_nebeCount = nebeCount;
      next_modeCfg = modeCfg;
      next_groupSel = groupSel;
      next_trinalCfg = trinalCfg;
      next_eocTx = eocTx;
      next_eocRx = eocRx;
      next_irqM4Flag = irqM4Flag;
      next_irqActFlag = irqActFlag;
      next_m56Prev = m56Prev;
      next_rdData = rdData;
      if (rdStb) begin
         next_rdData = readMux(sAddr);
         // reading the status nibble acknowledges both flags
         if (sAddr == `MCR_ADDR_IRQ_STATUS) begin
            next_irqM4Flag = 1'b0;
            next_irqActFlag = 1'b0;
         end
      end
      if (wrStb) begin
         if (sAddr == `MCR_ADDR_RESET_CTRL) begin
            next_resetCtrl = sData[3:0];
         end else if (sAddr == `MCR_ADDR_ACT_CTRL) begin
            next_actCtrl = sData[3:0];
         end else if (sAddr == `MCR_ADDR_IRQ_ENABLE) begin
            next_irqEnable = sData[3:0];
         end else if (sAddr == `MCR_ADDR_EOC_LO) begin
            next_eocTx[7:0] = sData;
         end else if (sAddr == `MCR_ADDR_EOC_HI) begin
            next_eocTx[11:8] = sData[3:0];
         end else if (sAddr == `MCR_ADDR_GROUP) begin
            next_groupSel = sData;
         end else if (initGroup) begin
            if (sAddr == `MCR_ADDR_TRINAL) begin
               next_trinalCfg = sData;
            end
         end else if (sAddr == `MCR_ADDR_M4_TX) begin
            next_m4Tx = sData;
         end else if (sAddr == `MCR_ADDR_M4_RX) begin
            next_m4Rx = sData;
         end else if (sAddr == `MCR_ADDR_M56_TX) begin
            next_m56Tx = sData;
         end else if (sAddr == `MCR_ADDR_FEBE) begin
            next_febeCount = sData;
         end else if (sAddr == `MCR_ADDR_NEBE) begin
            next_nebeCount = sData;
         end else if (sAddr == `MCR_ADDR_MODE) begin
            next_modeCfg = sData;
         end
      end
      // counters never clear on their own; a host write loads, then the event adds
      next_febeCount = countStep(next_febeCount, linkRx.febeErr);
      next_nebeCount = countStep(next_nebeCount, linkRx.nebeErr);
      // a changed validated m4 pattern lands in the receive register and flags
      if (m4Updated && m4Valid != next_m4Rx) begin
         next_m4Rx = m4Valid;
         next_irqM4Flag = 1'b1;
      end
      if (activationEvent) begin
         next_irqActFlag = 1'b1;
      end
      // m5/m6: every frame, or only after two equal frames
      if (linkRx.m5m6Valid) begin
         next_m56Prev = linkRx.m5m6;
         if (modeCfg[`MCR_MODE_M56_EVERY_BIT] || linkRx.m5m6 == m56Prev) begin
            next_m56Rx = linkRx.m5m6;
         end
      end
      if (eocStrobe) begin
         next_eocRx = eocValid;
      end
      // outgoing channels, eoc from the automatic responder in auto mode
      next_linkTx.m4 = m4Tx;
      next_linkTx.m5m6 = m56Tx;
      next_linkTx.eoc = autoMode ? eocAutoTx : eocTx;
      next_linkTx.febeBit = modeCfg[`MCR_MODE_FEBE_NEBE_BIT] ? !linkRx.nebeErr :
                            m56Tx[`MCR_M56_FEBE_BIT];
   end

   // all state of the bank
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         syncA <= 17'h1FFFF;
         syncB <= 17'h1FFFF;
         portState <= PORT_IDLE;
         resetCtrl <= `MCR_RST_NIBBLE;
         actCtrl <= `MCR_RST_NIBBLE;
         irqEnable <= `MCR_RST_NIBBLE;
         m4Tx <= `MCR_RST_BYTE_ONES;
         m4Rx <= `MCR_RST_BYTE_ONES;
         m56Tx <= `MCR_RST_BYTE_ONES;
         m56Rx <= `MCR_RST_BYTE_ONES;
         febeCount <= `MCR_RST_BYTE_ZERO;
         nebeCount <= `MCR_RST_BYTE_ZERO;
         modeCfg <= `MCR_RST_BYTE_ZERO;
         groupSel <= `MCR_RST_BYTE_ZERO;
         trinalCfg <= `MCR_RST_BYTE_ZERO;
         eocTx <= `MCR_RST_EOC;
         eocRx <= `MCR_RST_EOC;
         irqM4Flag <= 1'b0;
         irqActFlag <= 1'b0;
         m56Prev <= `MCR_RST_BYTE_ONES;
         rdData <= `MCR_RST_BYTE_ZERO;
         linkTx <= {`MCR_RST_BYTE_ONES, `MCR_RST_BYTE_ONES, `MCR_RST_EOC, 1'b1};
      end else begin
         syncA <= {pcpSelectN, pcpWriteN, pcpReadN, pcpAddr, pcpDataIn};
         syncB <= syncA;
         portState <= next_portState;
         resetCtrl <= next_resetCtrl;
         actCtrl <= next_actCtrl;
         irqEnable <= next_irqEnable;
         m4Tx <= next_m4Tx;
         m4Rx <= next_m4Rx;
         m56Tx <= next_m56Tx;
         m56Rx <= next_m56Rx;
         febeCount <= next_febeCount;
         nebeCount <= next_nebeCount;
         modeCfg <= next_modeCfg;
         groupSel <= next_groupSel;
         trinalCfg <= next_trinalCfg;
         eocTx <= next_eocTx;
         eocRx <= next_eocRx;
         irqM4Flag <= next_irqM4Flag;
         irqActFlag <= next_irqActFlag;
         m56Prev <= next_m56Prev;
         rdData <= next_rdData;
         linkTx <= next_linkTx;
      end
   end
endmodule // mcr_regs

/* sim/mcr_host_model.sv */
// host model on the parallel control port
module mcr_host_model (
   input wire logic clock,
   input wire logic [7:0] pcpDataOut,
   input wire logic pcpDataOe,
   output logic pcpSelectN,
   output logic pcpWriteN,
   output logic pcpReadN,
   output logic [5:0] pcpAddr,
   output logic [7:0] pcpDataIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus, strobes high
   initial {pcpSelectN, pcpWriteN, pcpReadN, pcpAddr, pcpDataIn} = {3'h7, 6'h3F, 8'hA5};
   // strobes low four clocks, then three idle, so the synchroniser sees both
   task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(posedge clock);
      {pcpSelectN, pcpWriteN, pcpReadN, pcpAddr} <= {1'b0, !wr, wr, a};
      pcpDataIn <= wr ? d : ~pcpDataIn;
      repeat (4) @(posedge clock);
      q = (pcpDataOe === 1'b1) ? pcpDataOut : 8'hEE; // no answer gives a marked value
      {pcpSelectN, pcpWriteN, pcpReadN} <= 3'h7;
      pcpDataIn <= ~pcpDataIn; // released lines never keep the last value
      repeat (3) @(posedge clock);
   endtask
endmodule // mcr_host_model

/* sim/mcr_regs_assertions.sv */
// port-level checks for the maintenance channel register bank
module mcr_regs_assertions import mcr_pkg::*; (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic pcpWriteN,
   input wire logic pcpReadN,
   input wire logic [5:0] pcpAddr,
   input wire logic pcpDataOe,
   input wire mcr_link_rx_t linkRx,
   input wire mcr_link_tx_t linkTx,
   input wire logic activationEvent,
   input wire logic softReset,
   input wire logic loopbackActive,
   input wire logic m4ChannelInterrupt,
   input wire logic activationDchannelInterrupt
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // outputs move only for their own cause, with the two-flop pin delay
   property p_oe; pcpDataOe |-> !$past(pcpReadN, 2); endproperty
   a_oe: assert property (p_oe) else $error("oe without read");
   property p_m4; $changed(linkTx.m4) |-> $past(!pcpWriteN && pcpAddr == 6'h10, 4); endproperty
   a_m4: assert property (p_m4) else $error("m4 out moved");
   property p_m56; $changed(linkTx.m5m6) |-> $past(!pcpWriteN && pcpAddr == 6'h12, 4);
   endproperty
   a_m56: assert property (p_m56) else $error("m5m6 out moved");
   property p_sr; $rose(softReset) |-> $past(!pcpWriteN && pcpAddr == 6'h00, 3); endproperty
   a_sr: assert property (p_sr) else $error("soft reset rose");
   property p_m4i; $rose(m4ChannelInterrupt) |-> $past(linkRx.m4Valid, 2) || $past(!pcpWriteN, 3);
   endproperty
   a_m4i: assert property (p_m4i) else $error("m4 irq rose");
   property p_ai; $rose(activationDchannelInterrupt) |-> $past(activationEvent) || $past(!pcpWriteN, 3);
   endproperty
   a_ai: assert property (p_ai) else $error("act irq rose");
   property p_lb; $rose(loopbackActive) |-> $past(linkRx.eocValid);
   endproperty
   a_lb: assert property (p_lb) else $error("loopback rose");
   property p_lbe; $rose(loopbackActive) |-> ##[0:2] linkTx.eoc[7:0] == 8'h50; endproperty
   a_lbe: assert property (p_lbe) else $error("no echo");
endmodule // mcr_regs_assertions
bind mcr_regs mcr_regs_assertions assertChecker (.*);

/* sim/mcr_regs_tb_top.sv */
// self-checking bench for the maintenance channel register bank
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
$display("unexpected at %0t: got %h", $time, g); end end
module mcr_regs_tb_top import mcr_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst_n, pcpSelectN, pcpWriteN, pcpReadN, pcpDataOe, activationEvent;
   logic softReset, activationRequest, customerEnable, loopbackActive;
   logic m4ChannelInterrupt, activationDchannelInterrupt;
   logic [5:0] pcpAddr;
   logic [7:0] pcpDataIn, pcpDataOut, q;
   logic [3:0] statusIn = 4'h0; // status nibble, idle until activation starts
   mcr_link_rx_t linkRx;
   mcr_link_tx_t linkTx;
   int n_fail = 0, total_checks = 0;
   mcr_regs DUT (.*);
   mcr_host_model HOST (.*);
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      HOST.access(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      HOST.access(1'b0, a, 8'h00, q);
      `CHK(q, e)
   endtask
   // one-cycle valid and error pulses, data left standing
   task automatic link(input mcr_link_rx_t v);
      @(posedge clock);
      linkRx <= v;
      @(posedge clock);
      linkRx <= v & ~33'h001008007;
      repeat (3) @(posedge clock);
   endtask
   task automatic t_regs;
      rd(6'h10, 8'hFF);
      rd(6'h3F, 8'h00);
      wr(6'h00, 8'h08);
      `CHK(softReset, 1'b1)
      wr(6'h00, 8'h00);
      wr(6'h10, 8'h77);
      wr(6'h11, 8'h7F);
      wr(6'h12, 8'hF0);
      wr(6'h19, 8'h1C);
      wr(6'h1A, 8'h01);
      wr(6'h17, 8'h01);
      rd(6'h10, 8'h00);
      wr(6'h1A, 8'h00);
      rd(6'h17, 8'h00);
      rd(6'h19, 8'h1C);
      wr(6'h04, 8'h0A);
      `CHK({linkTx.m4, linkTx.m5m6}, 16'h77F0)
      $display("t_regs done");
   endtask
   // act needs three equal frames, a dual check would fire one frame early
   task automatic t_m4;
      repeat (3) link({8'h7F, 1'b1, 8'hFF, 1'b0, 12'hFFF, 3'h0});
      rd(6'h03, 8'h02);
      repeat (2) link({8'hFF, 1'b1, 8'hFF, 1'b0, 12'hFFF, 3'h0});
      `CHK(m4ChannelInterrupt, 1'b0)
      link({8'hFF, 1'b1, 8'hFF, 1'b0, 12'hFFF, 3'h0});
      `CHK(m4ChannelInterrupt, 1'b1)
      rd(6'h11, 8'hFF);
      $display("t_m4 done");
   endtask
   task automatic t_act;
      statusIn <= 4'h1;
      rd(6'h01, 8'h01);
      wr(6'h10, 8'h77);
      wr(6'h02, 8'h08);
      `CHK({activationRequest, customerEnable}, 2'h2)
      activationEvent <= 1'b1;
      @(posedge clock);
      activationEvent <= 1'b0;
      repeat (2) @(posedge clock);
      `CHK(activationDchannelInterrupt, 1'b1)
      rd(6'h03, 8'h0A);
      rd(6'h03, 8'h00);
      `CHK(m4ChannelInterrupt, 1'b0)
      $display("t_act done");
   endtask
   // near-end counter saturates at the top, far-end counter counts both far-end errors
   task automatic t_cnt;
      wr(6'h15, 8'hFE);
      repeat (2) link({8'hFF, 1'b0, 8'h5A, 1'b1, 12'hFFF, 3'h3});
      rd(6'h15, 8'hFF);
      rd(6'h14, 8'h02);
      rd(6'h13, 8'h5A);
      $display("t_cnt done");
   endtask
   task automatic t_eoc;
      repeat (2) link({8'hFF, 1'b0, 8'h5A, 1'b0, 12'h350, 3'h4});
      `CHK(loopbackActive, 1'b0)
      link({8'hFF, 1'b0, 8'h5A, 1'b0, 12'h350, 3'h4});
      `CHK(loopbackActive, 1'b1)
      `CHK(linkTx.eoc, 12'h350)
      rd(6'h06, 8'h50);
      rd(6'h07, 8'h03);
      repeat (3) link({8'hFF, 1'b0, 8'h5A, 1'b0, 12'h3FF, 3'h4});
      `CHK(loopbackActive, 1'b0)
      // line-end setup in non-automatic mode: host eoc goes out as written
      wr(6'h19, 8'h9C);
      wr(6'h10, 8'h7F);
      wr(6'h06, 8'hFF);
      wr(6'h07, 8'h01);
      `CHK({linkTx.febeBit, linkTx.m4, linkTx.eoc}, 21'h17F1FF)
      $display("t_eoc done");
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      {rst_n, activationEvent, linkRx} = '0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      t_regs();
      t_m4();
      t_act();
      t_cnt();
      t_eoc();
      close_out();
   end
   // hang guard, far beyond the few hundred clocks the tests take
   initial begin
      #200000;
      n_fail++;
      close_out();
   end
endmodule // mcr_regs_tb_top
